// file: pkg/sdw_pkg.sv
// ============================================================
// Link constants, command codes and timing
package sdw_pkg;
   localparam int DQ_W  = 40;
   localparam int ROW_W = 13;
   localparam int COL_W = 11;
   localparam int BANKS = 4;

   // Pin code {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_BT  = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;

   localparam int ALL_BANK_SELECT_BIT  = 10;
   localparam int MODE_BL_LSB          = 0;
   localparam int MODE_LATENCY_LSB     = 4;
   localparam int WRITE_BURST_MODE_BIT = 9;
   localparam logic [ROW_W-1:0] MODE_RST = 13'h0022;
   localparam logic [2:0] READ_LATENCY_2 = 3'h2;

   // Timing in ns and derived cycles at 125 MHz
   localparam int CLK_NS               = 8;
   localparam int WRITE_RECOVERY_NS    = 15;
   localparam int AP_EXTRA_NS          = 7;
   localparam int PRECHARGE_PERIOD_NS  = 20;
   localparam int ROW_TO_COL_NS        = 20;
   localparam int REFRESH_PERIOD_MS    = 32;
   localparam int WR_CYC    = (WRITE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
   localparam int AP_WR_CYC = (CLK_NS + AP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRECH_CYC = (PRECHARGE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRCD_CYC  = (ROW_TO_COL_NS + CLK_NS - 1) / CLK_NS;
   localparam int REFRESH_CYC = REFRESH_PERIOD_MS * 1000000 / CLK_NS;

   // Register offsets of the controller
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDLO = 8'h08;
   localparam logic [7:0] REG_WDHI = 8'h0c;
   localparam logic [7:0] REG_CMD  = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   localparam logic [7:0] REG_RDLO = 8'h18;
   localparam logic [7:0] REG_RDHI = 8'h1c;
   localparam int ADDR_BANK_LSB = 16;

   typedef enum logic [1:0] {sdw_bk_idle, sdw_bk_active, sdw_bk_prech, sdw_bk_wrec} sdw_bank_e;

   // Burst length from mode field, 0 means full page
   function automatic logic [COL_W:0] sdw_burst_len(input logic [2:0] code);
      case (code)
         3'h0: sdw_burst_len = 12'h001;
         3'h1: sdw_burst_len = 12'h002;
         3'h2: sdw_burst_len = 12'h004;
         3'h3: sdw_burst_len = 12'h008;
         default: sdw_burst_len = 12'h000;
      endcase
   endfunction : sdw_burst_len

   // Column of element n, wrapping in the burst block or the page
   function automatic logic [COL_W-1:0] sdw_col(input logic [COL_W-1:0] start, input logic [COL_W:0] n,
                                               input logic [COL_W:0] len);
      logic [COL_W-1:0] mask;
      logic [COL_W-1:0] sum;
      mask = (len == 12'h000) ? 11'h7ff : 11'(len - 12'h001);
      sum  = start + n[COL_W-1:0];
      sdw_col = (start & ~mask) | (sum & mask);
   endfunction : sdw_col
endpackage : sdw_pkg

// file: pkg/sdw_if.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Command pins and shared data lines between the two ends
interface sdw_if (input wire logic clk);
   import sdw_pkg::*;
   logic            cs_n;
   logic            ras_n;
   logic            cas_n;
   logic            we_n;
   logic            cke;
   logic [1:0]      ba;
   logic [ROW_W-1:0] addr;
   logic            dqm;
   logic [DQ_W-1:0] ctl_dq_o;
   logic            ctl_dq_oe_n;
   logic [DQ_W-1:0] dev_dq_o;
   logic            dev_dq_oe_n;
   logic [DQ_W-1:0] dq;

   // Wire level from the enables; an undriven bus reads zero
   assign dq = !dev_dq_oe_n ? dev_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);

   modport dev (input clk, cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq, output dev_dq_o, dev_dq_oe_n);
   modport ctl (input clk, dq, output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, ctl_dq_o, ctl_dq_oe_n);
endinterface : sdw_if
`default_nettype wire

// file: logic/sdw_controller.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Memory controller end: AHB-Lite registers drive single commands
module sdw_controller
   import sdw_pkg::*;
#(
   parameter int REFRESH_LIMIT = REFRESH_CYC
)
(
   sdw_if.ctl               link,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);
   typedef enum {sdw_c_idle, sdw_c_issue, sdw_c_gap} sdw_ctl_e;

   logic              clk;
   sdw_ctl_e          st;
   logic              wr_ph;
   logic [7:0]        wr_off;
   logic              ctrl_pd;
   logic [17:0]       addr_reg;
   logic [DQ_W-1:0]   wd;
   logic [DQ_W-1:0]   rd;
   logic              rd_valid;
   logic              busy;
   logic [3:0]        code;
   logic [3:0]        gap;
   logic [3:0]        cnt;
   logic [2:0]        rd_lat;
   logic [31:0]       pd_cnt;
   logic              start;
   logic              timeout;

   assign clk     = link.clk;
   assign start   = wr_ph && wr_off == REG_CMD && !busy && link.cke;
   assign timeout = !link.cke && pd_cnt >= 32'(REFRESH_LIMIT - 1);

   // ============================================================
   // Bus slave
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0;
         wr_ph     <= 1'b0;
         wr_off    <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_ph     <= hsel && hready && htrans[1] && hwrite;
         wr_off    <= haddr[7:0];
         if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
               REG_CTRL: hrdata <= {31'h0, ctrl_pd};
               REG_ADDR: hrdata <= {14'h0, addr_reg};
               REG_WDLO: hrdata <= wd[31:0];
               REG_WDHI: hrdata <= {24'h0, wd[DQ_W-1:32]};
               REG_STAT: hrdata <= {29'h0, rd_valid, !link.cke, busy};
               REG_RDLO: hrdata <= rd[31:0];
               REG_RDHI: hrdata <= {24'h0, rd[DQ_W-1:32]};
               default:  hrdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_reg <= 18'h0;
         wd       <= '0;
      end else if (wr_ph) begin
         if (wr_off == REG_ADDR) addr_reg <= hwdata[17:0];
         if (wr_off == REG_WDLO) wd[31:0] <= hwdata;
         if (wr_off == REG_WDHI) wd[DQ_W-1:32] <= hwdata[7:0];
      end
   end

   // ============================================================
   // Power-down and suspend request, forced out before refresh is due
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_pd   <= 1'b0;
         pd_cnt    <= 32'h0;
         link.cke  <= 1'b1;
      end else begin
         if (timeout) ctrl_pd <= 1'b0;
         else if (wr_ph && wr_off == REG_CTRL) ctrl_pd <= hwdata[0];
         pd_cnt   <= link.cke ? 32'h0 : pd_cnt + 32'h1;
         link.cke <= !(ctrl_pd && !timeout && st == sdw_c_idle);
      end
   end

   // ============================================================
   // Command sequencer with recovery gaps
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st               <= sdw_c_idle;
         busy             <= 1'b0;
         code             <= CMD_NOP;
         gap              <= 4'h1;
         cnt              <= 4'h0;
         rd_lat           <= READ_LATENCY_2;
         {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
         link.ba          <= 2'h0;
         link.addr        <= '0;
         link.dqm         <= 1'b1;
         link.ctl_dq_o    <= '0;
         link.ctl_dq_oe_n <= 1'b1;
      end else begin
         case (st)
            sdw_c_idle: begin
               if (start) begin
                  code      <= hwdata[3:0];
                  {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= hwdata[3:0];
                  link.ba   <= addr_reg[ADDR_BANK_LSB+1:ADDR_BANK_LSB];
                  link.addr <= addr_reg[ROW_W-1:0];
                  link.dqm  <= !(hwdata[3:0] == CMD_WR || hwdata[3:0] == CMD_RD);
                  link.ctl_dq_o    <= wd;
                  link.ctl_dq_oe_n <= hwdata[3:0] != CMD_WR;
                  case (hwdata[3:0])
                     CMD_WR:  gap <= 4'(WR_CYC + 1);
                     CMD_PRE: gap <= 4'(PRECH_CYC);
                     CMD_RD:  gap <= {1'b0, rd_lat} + 4'h1;
                     CMD_ACT: gap <= 4'(TRCD_CYC);
                     CMD_LMR: gap <= 4'h2;
                     default: gap <= 4'h1;
                  endcase
                  busy <= 1'b1;
                  st   <= sdw_c_issue;
               end
            end
            sdw_c_issue: begin
               {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
               link.dqm         <= code != CMD_RD;
               link.ctl_dq_oe_n <= 1'b1;
               if (code == CMD_LMR) rd_lat <= link.addr[MODE_LATENCY_LSB+2:MODE_LATENCY_LSB];
               cnt <= 4'h1;
               st  <= sdw_c_gap;
            end
            sdw_c_gap: begin
               cnt <= cnt + 4'h1;
               if (cnt >= gap) begin
                  link.dqm <= 1'b1;
                  busy     <= 1'b0;
                  st       <= sdw_c_idle;
               end
            end
            default: st <= sdw_c_idle;
         endcase
      end
   end

   // Read capture; a new capture wins over a software clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd       <= '0;
         rd_valid <= 1'b0;
      end else if (st == sdw_c_gap && code == CMD_RD && cnt == {1'b0, rd_lat}) begin
         rd       <= link.dq;
         rd_valid <= 1'b1;
      end else if (wr_ph && wr_off == REG_STAT && hwdata[2]) begin
         rd_valid <= 1'b0;
      end
   end
endmodule : sdw_controller
`default_nettype wire

// file: logic/sdw_device.sv
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// What this block does
// - First write datum taken with WRITE command
// - After fixed burst, ignore data, stay High-Z
// - Full-page burst wraps until terminated
// - New WRITE any cycle truncates prior burst
// - Controller waits write recovery before PRECHARGE
// - Auto-precharge recovery is one clock plus
// - Controller masks data around truncating PRECHARGE
// - Controller waits precharge period after PRECHARGE
// - Terminate ignores its own cycle's data
// - All-bank bit picks one or all banks
// - Idle bank needs ACTIVE before access
// - CKE low, NOP, no access: power-down
// - Controller leaves power-down within refresh period
// - CKE high with NOP exits power-down
// - CKE low during burst: clock suspend
// - Suspended edges ignore inputs, hold state; bank precharge and recovery timers keep counting
// - CKE high resumes next edge; bounded suspend
// - Write burst mode bit forces single writes
// - READ cuts auto-precharge read, precharge starts
// - WRITE cuts auto-precharge read at once
// - READ cuts auto-precharge write, recovery starts
// - WRITE cuts auto-precharge write, recovery starts
// - After READ, no further burst writes
module sdw_device
   import sdw_pkg::*;
(
   sdw_if.dev                      link,
   input  wire logic               rst,
   output logic                    mem_we,
   output logic                    mem_re,
   output logic [1:0]              mem_bank,
   output logic [ROW_W-1:0]        mem_row,
   output logic [COL_W-1:0]        mem_col,
   output logic [DQ_W-1:0]         mem_wdata,
   input  wire logic [DQ_W-1:0]    mem_rdata,
   output logic                    power_down,
   output logic                    power_down_active,
   output logic                    clock_suspended
);
   logic               clk;
   logic [3:0]         cmd;
   logic               cke_q;
   logic               run;
   logic [ROW_W-1:0]   mode;
   sdw_bank_e          bank_st  [BANKS];
   logic [2:0]         bank_cnt [BANKS];
   logic [ROW_W-1:0]   open_row [BANKS];
   logic               burst_on;
   logic               burst_wr;
   logic               burst_ap;
   logic [1:0]         burst_bank;
   logic [COL_W-1:0]   burst_col;
   logic [COL_W:0]     burst_len;
   logic [COL_W:0]     burst_cnt;
   logic               is_rd;
   logic               is_wr;
   logic               is_acc;
   logic               cont;
   logic               burst_last;
   logic               old_close;
   logic               new_close;
   logic               all_idle;
   logic [3:0]         pre_mask;
   logic [COL_W:0]     new_len;
   logic [COL_W-1:0]   cmd_col;
   logic               lat2;
   logic               dqm_q;
   logic               stage_v;
   logic [DQ_W-1:0]    stage;

   assign clk     = link.clk;
   assign cmd     = link.cs_n ? CMD_NOP : {1'b0, link.ras_n, link.cas_n, link.we_n};
   assign run     = cke_q && !power_down;
   assign cmd_col = {link.addr[11], link.addr[9:0]};
   assign lat2    = mode[MODE_LATENCY_LSB+2:MODE_LATENCY_LSB] == READ_LATENCY_2;

   // ============================================================
   // Command decode
   always_comb begin
      all_idle = 1'b1;
      for (int b = 0; b < BANKS; b++) begin
         if (bank_st[b] != sdw_bk_idle) all_idle = 1'b0;
      end
      is_rd  = run && cmd == CMD_RD && bank_st[link.ba] == sdw_bk_active;
      is_wr  = run && cmd == CMD_WR && bank_st[link.ba] == sdw_bk_active;
      is_acc = is_rd || is_wr;
      if (!(run && cmd == CMD_PRE)) pre_mask = 4'h0;
      else if (link.addr[ALL_BANK_SELECT_BIT]) pre_mask = 4'hf;
      else pre_mask = 4'h1 << link.ba;
      new_len = (is_wr && mode[WRITE_BURST_MODE_BIT]) ? 12'h001
              : sdw_burst_len(mode[MODE_BL_LSB+2:MODE_BL_LSB]);
      cont       = run && burst_on && !is_acc && cmd != CMD_BT && !pre_mask[burst_bank];
      burst_last = burst_len != 12'h000 && burst_cnt + 12'h001 == burst_len;
      old_close  = run && burst_on && burst_ap && (is_acc || (cont && burst_last));
      new_close  = is_acc && link.addr[ALL_BANK_SELECT_BIT] && new_len == 12'h001;
   end

   // ============================================================
   // Mode register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) mode <= MODE_RST;
      else if (run && cmd == CMD_LMR && all_idle) mode <= link.addr;
   end

   // ============================================================
   // Bank states, precharge and auto-precharge timers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < BANKS; b++) begin
            bank_st[b]  <= sdw_bk_idle;
            bank_cnt[b] <= 3'h0;
            open_row[b] <= '0;
         end
      end else begin
         for (int b = 0; b < BANKS; b++) begin
            if (pre_mask[b] && bank_st[b] == sdw_bk_active) begin
               bank_st[b]  <= sdw_bk_prech;
               bank_cnt[b] <= 3'(PRECH_CYC - 1);
            end else if (run && cmd == CMD_ACT && link.ba == 2'(b) && bank_st[b] == sdw_bk_idle) begin
               bank_st[b]  <= sdw_bk_active;
               open_row[b] <= link.addr;
            end else if ((old_close && burst_bank == 2'(b) && burst_wr)
                         || (new_close && link.ba == 2'(b) && is_wr)) begin
               bank_st[b]  <= sdw_bk_wrec;
               bank_cnt[b] <= 3'(AP_WR_CYC - 1);
            end else if ((old_close && burst_bank == 2'(b)) || (new_close && link.ba == 2'(b))) begin
               bank_st[b]  <= sdw_bk_prech;
               bank_cnt[b] <= 3'(PRECH_CYC - 1);
            end else if (bank_st[b] == sdw_bk_prech || bank_st[b] == sdw_bk_wrec) begin
               if (bank_cnt[b] != 3'h0) begin
                  bank_cnt[b] <= bank_cnt[b] - 3'h1;
               end else if (bank_st[b] == sdw_bk_wrec) begin
                  bank_st[b]  <= sdw_bk_prech;
                  bank_cnt[b] <= 3'(PRECH_CYC - 1);
               end else begin
                  bank_st[b]  <= sdw_bk_idle;
               end
            end
         end
      end
   end

   // ============================================================
   // Burst tracking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         burst_on   <= 1'b0;
         burst_wr   <= 1'b0;
         burst_ap   <= 1'b0;
         burst_bank <= 2'h0;
         burst_col  <= '0;
         burst_len  <= '0;
         burst_cnt  <= '0;
      end else if (is_acc) begin
         burst_on   <= new_len != 12'h001;
         burst_wr   <= is_wr;
         burst_ap   <= link.addr[ALL_BANK_SELECT_BIT];
         burst_bank <= link.ba;
         burst_col  <= cmd_col;
         burst_len  <= new_len;
         burst_cnt  <= 12'h001;
      end else if (run && burst_on) begin
         if (!cont || burst_last) burst_on <= 1'b0;
         burst_cnt <= burst_cnt + 12'h001;
      end
   end

   // ============================================================
   // Array port; writes only on live edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_we    <= 1'b0;
         mem_re    <= 1'b0;
         mem_bank  <= 2'h0;
         mem_row   <= '0;
         mem_col   <= '0;
         mem_wdata <= '0;
      end else begin
         mem_we <= 1'b0;
         if (is_acc) begin
            mem_we    <= is_wr && !link.dqm;
            mem_re    <= is_rd;
            mem_bank  <= link.ba;
            mem_row   <= open_row[link.ba];
            mem_col   <= cmd_col;
            mem_wdata <= link.dq;
         end else if (cont) begin
            mem_we    <= burst_wr && !link.dqm;
            mem_re    <= !burst_wr;
            mem_bank  <= burst_bank;
            mem_row   <= open_row[burst_bank];
            mem_col   <= sdw_col(burst_col, burst_cnt, burst_len);
            mem_wdata <= link.dq;
         end else if (run) begin
            mem_re    <= 1'b0;
         end
      end
   end

   // ============================================================
   // Read data to the pins after the read latency
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dqm_q            <= 1'b0;
         stage            <= '0;
         stage_v          <= 1'b0;
         link.dev_dq_o    <= '0;
         link.dev_dq_oe_n <= 1'b1;
      end else if (run) begin
         dqm_q   <= link.dqm;
         stage   <= mem_rdata;
         stage_v <= mem_re && !is_wr;
         if (is_wr) begin
            link.dev_dq_oe_n <= 1'b1;
         end else begin
            link.dev_dq_o    <= lat2 ? mem_rdata : stage;
            link.dev_dq_oe_n <= !((lat2 ? mem_re : stage_v) && !dqm_q);
         end
      end else if (power_down) begin
         link.dev_dq_oe_n <= 1'b1;
      end
   end

   // ============================================================
   // Power-down and clock suspend
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cke_q             <= 1'b1;
         power_down        <= 1'b0;
         power_down_active <= 1'b0;
         clock_suspended   <= 1'b0;
      end else begin
         cke_q           <= link.cke;
         clock_suspended <= !link.cke && burst_on && !power_down;
         if (!power_down && cke_q && !link.cke && cmd == CMD_NOP && !burst_on && !mem_re && !stage_v) begin
            power_down        <= 1'b1;
            power_down_active <= !all_idle;
         end else if (power_down && link.cke && cmd == CMD_NOP) begin
            power_down        <= 1'b0;
            power_down_active <= 1'b0;
         end
      end
   end
endmodule : sdw_device
`default_nettype wire

// file: verif/sdw_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Link checks
module sdw_link_assertions
   import sdw_pkg::*;
#(parameter int LIMIT = 50)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic dqm,
   input wire logic ctl_dq_oe_n,
   input wire logic dev_dq_oe_n
);
   logic        wr, pre, nop;
   logic [15:0] lowc;
   assign wr  = {cs_n, ras_n, cas_n, we_n} == CMD_WR;
   assign pre = {cs_n, ras_n, cas_n, we_n} == CMD_PRE;
   assign nop = cs_n | ({cs_n, ras_n, cas_n, we_n} == CMD_NOP);
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         lowc <= '0;
      else
         lowc <= cke ? '0 : lowc + 16'h0001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wr_data_a: assert property (wr |-> !ctl_dq_oe_n && !dqm) else $error("write without data");
   dev_quiet_a: assert property (wr |=> dev_dq_oe_n [*2]) else $error("device drove after write");
   pre_mask_a: assert property (pre |-> dqm && $past(dqm)) else $error("mask missing at precharge");
   pre_recov_a: assert property (pre |-> !$past(wr)) else $error("precharge too early");
   pre_wait_a: assert property (pre |=> nop [*2]) else $error("command in precharge period");
   pd_entry_a: assert property ($fell(cke) |-> nop) else $error("cke fell with command");
   pd_exit_a: assert property ($rose(cke) |-> nop) else $error("cke rose with command");
   low_bound_a: assert property (lowc <= 16'(LIMIT + 2)) else $error("cke low too long");
endmodule : sdw_link_assertions
`default_nettype wire

// file: verif/sdram_write_precharge_cke_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module sdram_write_precharge_cke_control_test;
   import sdw_pkg::*;
   logic             clk, rst, hsel, hwrite, hready, hresp, mem_we, mem_re, pd, pda, cs;
   logic [1:0]       htrans, mem_bank;
   logic [31:0]      haddr, hwdata, hrdata, q, rd;
   logic [9:0]       c10;
   logic [ROW_W-1:0] mem_row;
   logic [COL_W-1:0] mem_col, wcol;
   logic [DQ_W-1:0]  mem_wdata, mem_rdata, wdat, exp_d;
   logic [DQ_W-1:0]  mem [0:2047];
   int               errors, comparisons, nwr, seed, k;
   sdw_if link (.clk(clk));
   assign mem_rdata = mem[mem_col];
   sdw_controller #(.REFRESH_LIMIT(50)) sdw_controller_i (.link(link.ctl), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata));
   sdw_device sdw_device_i (.link(link.dev), .rst(rst), .mem_we(mem_we), .mem_re(mem_re), .mem_bank(mem_bank),
      .mem_row(mem_row), .mem_col(mem_col), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .power_down(pd),
      .power_down_active(pda), .clock_suspended(cs));
   sdw_link_assertions #(.LIMIT(50)) sdw_link_assertions_i (.clk(clk), .rst(rst), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke), .dqm(link.dqm),
      .ctl_dq_oe_n(link.ctl_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n));
   // ============================================================
   // Array model
   always @(posedge clk) begin
      if (mem_we === 1'b1) begin
         nwr++;
         wcol = mem_col;
         wdat = mem_wdata;
         mem[mem_col] = mem_wdata;
      end
   end
   // ============================================================
   // Tasks
   task automatic close_out;
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [DQ_W-1:0] e, input logic [DQ_W-1:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bound(input int n);
      if (n >= 100) begin
         errors++;
         $display("ERROR wait expected done seen timeout");
         close_out();
      end
   endtask : bound
   task automatic edge_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      bound(n);
   endtask : edge_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      edge_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      q = hrdata;
   endtask : bus
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] ad);
      int n;
      bus(1'b1, REG_ADDR, {14'h0, b, 3'h0, ad});
      bus(1'b1, REG_CMD, {28'h0, c});
      repeat (2) @(posedge clk);
      n = 0;
      do begin
         bus(1'b0, REG_STAT, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      bound(n);
   endtask : cmd
   // ============================================================
   // Sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      seed = 75;
      {errors, comparisons, nwr} = '0;
      {rst, hsel, haddr, htrans, hwrite, hwdata} <= {1'b1, 68'h0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cmd(CMD_ACT, 2'h1, 13'h0123);
      for (k = 0; k < 4; k++) begin
         exp_d = DQ_W'({$random(seed), $random(seed)});
         c10 = (k == 0) ? 10'h3ff : 10'($random(seed));
         bus(1'b1, REG_WDLO, exp_d[31:0]);
         bus(1'b1, REG_WDHI, {24'h0, exp_d[39:32]});
         cmd(CMD_WR, 2'h1, {3'h0, c10});
         chk("write column", DQ_W'({1'b0, c10}), DQ_W'(wcol));
         chk("write data", exp_d, wdat);
         cmd(CMD_RD, 2'h1, {3'h0, c10});
         bus(1'b0, REG_RDLO, 32'h0);
         rd = q;
         bus(1'b0, REG_RDHI, 32'h0);
         chk("read data", exp_d, {q[7:0], rd});
         chk("write count", DQ_W'(k + 1), DQ_W'(nwr));
      end
      $display("test write and read done");
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      chk("active power-down", 40'h3, {38'h0, pd, pda});
      bus(1'b1, REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      chk("power-down exit", 40'h0, {39'h0, pd});
      cmd(CMD_PRE, 2'h1, 13'h0000);
      cmd(CMD_WR, 2'h1, 13'h0005);
      chk("write to idle bank", 40'h4, DQ_W'(nwr));
      $display("test precharge done");
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      chk("precharge power-down", 40'h2, {38'h0, pd, pda});
      repeat (60) @(posedge clk);
      chk("refresh bound exit", 40'h0, {39'h0, pd});
      $display("test power-down done");
      cmd(CMD_LMR, 2'h0, 13'h0027);
      cmd(CMD_ACT, 2'h2, 13'h0040);
      cmd(CMD_WR, 2'h2, 13'h0000);
      chk("write bank and row", 40'h4040, DQ_W'({mem_bank, mem_row}));
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      chk("clock suspend", 40'h1, {38'h0, pd, cs});
      repeat (56) @(posedge clk);
      chk("suspend exit", 40'h0, {39'h0, cs});
      cmd(CMD_BT, 2'h0, 13'h0000);
      chk("suspended write count", 40'h5, DQ_W'(nwr));
      $display("test clock suspend done");
      close_out();
   end
endmodule : sdram_write_precharge_cke_control_test
`default_nettype wire
